// File: inc/ivp_pkg.sv
// shared constants and types for the interrupt vector and priority controller
package ivp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // source counts
  // request slots 0..71 cover every listed request number
  localparam int IVP_NUM_IRQ = 72;
  // exception and software trap slots, vectors 0..7
  localparam int IVP_NUM_TRAP = 8;

  // request numbers shown as reserved; these slots never raise a flag
  localparam logic [71:0] IVP_IRQ_RSVD = (72'h01 << 15) | (72'h01 << 18) | (72'h01 << 45) |
                                         (72'h01 << 57) | (72'h01 << 58) | (72'h01 << 59) |
                                         (72'h01 << 60) | (72'h01 << 62) | (72'h01 << 63) |
                                         (72'h01 << 64) | (72'h01 << 67);
  // 61 implemented request sources
  localparam logic [71:0] IVP_IRQ_IMPL = ~IVP_IRQ_RSVD;
  // 5 implemented traps: oscillator, address, stack, math, dma
  localparam logic [7:0] IVP_TRAP_IMPL = 8'h3e;

  ////////////////////////////////////////////////////////////////////////////
  // vector numbering and table layout (word indices, byte address / 2)
  // request n uses vector n plus this offset
  localparam logic [6:0] IVP_VEC_OFFSET = 7'h08;
  // first receive request of the first uart
  localparam int IVP_UART1_RX_IRQ = 11;
  // primary table starts at byte 0x000004
  localparam logic [7:0] IVP_PRI_BASE_WORD = 8'h02;
  // alternate table starts at byte 0x000104, same layout
  localparam logic [7:0] IVP_ALT_BASE_WORD = 8'h82;
  // number of slots in each table
  localparam int IVP_TABLE_SLOTS = 126;
  // alternate table select bit within the second control word
  localparam int IVP_ALT_SEL_BIT = 15;

  ////////////////////////////////////////////////////////////////////////////
  // levels, reset values, latencies
  // cpu level at which user requests are all blocked
  localparam logic [3:0] IVP_USER_BLOCK_LEVEL = 4'h7;
  // level given to trap vector 0; later traps sit one step lower each
  localparam logic [3:0] IVP_TRAP_LEVEL_TOP = 4'hf;
  // program counter value after reset
  localparam logic [23:0] IVP_RESET_ADDR = 24'h00_0000;
  // cycles from entry acknowledge to entry done
  localparam logic [3:0] IVP_ENTRY_CYCLES = 4'h4;
  // cycles from return request to return done
  localparam logic [3:0] IVP_RETURN_CYCLES = 4'h3;

  ////////////////////////////////////////////////////////////////////////////
  // types
  // per-source priority field, 0 disables the source
  typedef logic [2:0] ivp_prio_t;

  // latched pending vector status
  typedef struct packed {
    logic [6:0] pending_vector_number;
    logic [3:0] pending_priority_level;
  } ivp_pend_s;

  // service sequencing
  typedef enum logic [1:0] {
    IVP_IDLE,
    IVP_ENTRY,
    IVP_SERVICE,
    IVP_RETURN
  } ivp_state_e;

endpackage : ivp_pkg

// File: core/ivp_src_slot.sv
// one request source: optional input synchroniser and sticky request flag
`timescale 1ns/100ps

module ivp_src_slot #(
  parameter bit SYNC = 1'b1,
  parameter bit IMPL = 1'b1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic req_in,
  input wire logic clr,
  output logic flag
);

  // request after optional synchronising
  logic req_s;

  generate
    if (SYNC) begin : g_sync
      // first stage, read only by the second stage
      logic meta_reg;
      // second stage, safe to use
      logic stable_reg;
      // two flops because pins and foreign peripherals are asynchronous
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          meta_reg <= 1'b0;
          stable_reg <= 1'b0;
        end else begin
          meta_reg <= req_in;
          stable_reg <= meta_reg;
        end
      end
      assign req_s = stable_reg;
    end else begin : g_direct
      // same-clock source, no delay added
      assign req_s = req_in;
    end
  endgenerate

  // sticky flag; a set in the clear cycle wins so no event is lost
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flag <= 1'b0;
    end else if (!IMPL) begin
      // reserved slot stays quiet
      flag <= 1'b0;
    end else if (req_s) begin
      flag <= 1'b1;
    end else if (clr) begin
      flag <= 1'b0;
    end
  end

endmodule : ivp_src_slot

// File: core/ivp_vec_mem.sv
// vector table storage: 256 words of 24 bits, registered read
`timescale 1ns/100ps

module ivp_vec_mem (
  input wire logic clk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [7:0] wr_index,
  input wire logic [23:0] wr_data,
  input wire logic [7:0] rd_index,
  output logic [23:0] rd_data
);

  // both tables, indexed by program word address
  logic [23:0] mem [0:255];

  // program-side loading; no reset, contents are firmware
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_index] <= wr_data;
    end
  end

  // read data registered, one cycle after the index
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_data <= 24'h00_0000;
    end else begin
      rd_data <= mem[rd_index];
    end
  end

endmodule : ivp_vec_mem

// File: core/ivp_ctrl.sv
// interrupt vector and priority controller top level
`timescale 1ns/100ps

// Behaviour
// - merge all requests into one cpu request
// - eight trap slots, seven user priority levels
// - primary table at 000004h, 126 vectors
// - vector word gives service routine start address
// - lower vector address wins when otherwise equal
// - equal levels resolved by natural vector order
// - 61 sources, 5 traps, unique vectors
// - select bit 15 switches to alternate table
// - alternate table follows primary, same layout
// - fixed entry and return cycle counts
// - reset clears state, program counter zero
// - request n maps to vector n plus 8
// - uart one receive is request 11, vector 19
// - hardware sets flags, only software clears them
// - per-source priority field and enable bit
// - latch pending vector and level for reading
// - cpu level seven blocks users, not traps
module ivp_ctrl (
  input wire logic clk,
  input wire logic rst,
  input wire logic [ivp_pkg::IVP_NUM_IRQ-1:0] irq_req_raw,
  input wire logic [ivp_pkg::IVP_NUM_TRAP-1:0] trap_req,
  input wire logic [ivp_pkg::IVP_NUM_IRQ-1:0] irq_flag_clear,
  input wire logic [ivp_pkg::IVP_NUM_TRAP-1:0] trap_flag_clear,
  input wire logic [ivp_pkg::IVP_NUM_IRQ-1:0] irq_enable,
  input wire ivp_pkg::ivp_prio_t [ivp_pkg::IVP_NUM_IRQ-1:0] source_priority_bank,
  input wire logic [15:0] second_interrupt_control,
  input wire logic [3:0] cpu_priority_level,
  input wire logic entry_ack,
  input wire logic return_req,
  input wire logic vt_wr_en,
  input wire logic [7:0] vt_wr_index,
  input wire logic [23:0] vt_wr_data,
  output logic cpu_irq_req,
  output ivp_pkg::ivp_pend_s pending_vector_status,
  output logic [ivp_pkg::IVP_NUM_IRQ-1:0] request_flag_bank,
  output logic [ivp_pkg::IVP_NUM_TRAP-1:0] trap_flag_bank,
  output logic [23:0] isr_address,
  output logic entry_done,
  output logic return_done,
  output logic in_service
);
  import ivp_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // declarations

  // sequencer state
  ivp_state_e state_reg;
  ivp_state_e state_next;
  // latency counter shared by entry and return
  logic [3:0] cnt_reg;
  // trap arbitration result
  logic trap_hit;
  logic [2:0] trap_vec;
  // user arbitration result
  logic user_hit;
  logic user_ok;
  ivp_prio_t best_prio;
  logic [6:0] best_irq;
  // candidate for the next latch
  ivp_pend_s pend_next;
  logic req_next;
  // table word read during entry
  logic [7:0] rd_index;
  logic [23:0] rd_data;
  // entry and return counts reached
  logic entry_last;
  logic return_last;

  //////////////////////////////////////////////////////////////////////////////
  // request flags

  genvar g;
  generate
    for (g = 0; g < IVP_NUM_IRQ; g++) begin : g_irq
      // pins and peripherals arrive asynchronously
      ivp_src_slot #(
        .SYNC(1'b1),
        .IMPL(IVP_IRQ_IMPL[g])
      ) u_slot (
        .clk(clk),
        .rst(rst),
        .req_in(irq_req_raw[g]),
        .clr(irq_flag_clear[g]),
        .flag(request_flag_bank[g])
      );
    end
    for (g = 0; g < IVP_NUM_TRAP; g++) begin : g_trap
      // traps come from core logic on this clock
      ivp_src_slot #(
        .SYNC(1'b0),
        .IMPL(IVP_TRAP_IMPL[g])
      ) u_slot (
        .clk(clk),
        .rst(rst),
        .req_in(trap_req[g]),
        .clr(trap_flag_clear[g]),
        .flag(trap_flag_bank[g])
      );
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // arbitration

  // traps: lowest flagged vector wins
  always_comb begin
    trap_hit = 1'b0;
    trap_vec = 3'h0;
    // scan downward so lower vector wins
    for (int i = IVP_NUM_TRAP - 1; i >= 0; i--) begin
      if (trap_flag_bank[i]) begin
        trap_hit = 1'b1;
        trap_vec = 3'(i);
      end
    end
  end

  // users: highest level wins, ties go to the lower request number
  always_comb begin
    user_hit = 1'b0;
    best_prio = 3'h0;
    best_irq = 7'h00;
    // enable and nonzero level gate each source
    for (int i = IVP_NUM_IRQ - 1; i >= 0; i--) begin
      if (request_flag_bank[i] && irq_enable[i] && (source_priority_bank[i] != 3'h0) &&
          (!user_hit || (source_priority_bank[i] >= best_prio))) begin
        user_hit = 1'b1;
        best_prio = source_priority_bank[i];
        best_irq = 7'(i);
      end
    end
  end

  // qualify against the cpu level and form the status candidate
  always_comb begin
    // level seven and above leaves users out
    user_ok = user_hit && ({1'b0, best_prio} > cpu_priority_level) &&
              (cpu_priority_level < IVP_USER_BLOCK_LEVEL);
    pend_next = '0;
    if (trap_hit) begin
      // traps are nonmaskable, level falls with vector number
      pend_next.pending_vector_number = {4'h0, trap_vec};
      pend_next.pending_priority_level = IVP_TRAP_LEVEL_TOP - {1'b0, trap_vec};
    end else if (user_ok) begin
      // request n is vector n plus 8
      // request 11 lands on vector 19
      pend_next.pending_vector_number = best_irq + IVP_VEC_OFFSET;
      pend_next.pending_priority_level = {1'b0, best_prio};
    end
    // one request line to the cpu
    req_next = trap_hit || user_ok;
  end

  //////////////////////////////////////////////////////////////////////////////
  // request and status

  // request tracks arbitration only while idle; dropped during service
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cpu_irq_req <= 1'b0;
    end else if (state_next == IVP_IDLE) begin
      cpu_irq_req <= req_next;
    end else begin
      cpu_irq_req <= 1'b0;
    end
  end

  // latched vector number and new level
  // frozen from acknowledge to return so software reads the serviced one
  // refreshed on the same edges as the request, so both name one source
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pending_vector_status <= '0;
    end else if (state_next == IVP_IDLE) begin
      pending_vector_status <= pend_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // vector fetch

  // primary slots start at word two
  always_comb begin
    if (second_interrupt_control[IVP_ALT_SEL_BIT]) begin
      rd_index = IVP_ALT_BASE_WORD + {1'b0, pending_vector_status.pending_vector_number};
    end else begin
      rd_index = IVP_PRI_BASE_WORD + {1'b0, pending_vector_status.pending_vector_number};
    end
  end

  // table storage, loaded through the programming port
  ivp_vec_mem u_mem (
    .clk(clk),
    .rst(rst),
    .wr_en(vt_wr_en),
    .wr_index(vt_wr_index),
    .wr_data(vt_wr_data),
    .rd_index(rd_index),
    .rd_data(rd_data)
  );

  //////////////////////////////////////////////////////////////////////////////
  // sequencer

  // counts end at fixed values for every source
  assign entry_last = (cnt_reg == IVP_ENTRY_CYCLES - 4'h1);
  assign return_last = (cnt_reg == IVP_RETURN_CYCLES - 4'h1);

  // next state; nesting is left to the cpu, one service at a time here
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      IVP_IDLE: begin
        // acknowledge only counts against a live request
        if (entry_ack && cpu_irq_req) begin
          state_next = IVP_ENTRY;
        end
      end
      IVP_ENTRY: begin
        if (entry_last) begin
          state_next = IVP_SERVICE;
        end
      end
      IVP_SERVICE: begin
        if (return_req) begin
          state_next = IVP_RETURN;
        end
      end
      IVP_RETURN: begin
        if (return_last) begin
          state_next = IVP_IDLE;
        end
      end
      default: begin
        state_next = IVP_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= IVP_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // latency counter, restarts on every state change
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= 4'h0;
    end else if (state_next != state_reg) begin
      cnt_reg <= 4'h0;
    end else if (state_reg == IVP_ENTRY || state_reg == IVP_RETURN) begin
      cnt_reg <= cnt_reg + 4'h1;
    end
  end

  // service routine address taken from the table word
  // reset leaves the address at zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      isr_address <= IVP_RESET_ADDR;
    end else if (state_reg == IVP_ENTRY && entry_last) begin
      isr_address <= rd_data;
    end
  end

  // one-cycle completion strobes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      entry_done <= 1'b0;
      return_done <= 1'b0;
    end else begin
      entry_done <= (state_reg == IVP_ENTRY) && entry_last;
      return_done <= (state_reg == IVP_RETURN) && return_last;
    end
  end

  // busy level from acknowledge to return done
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      in_service <= 1'b0;
    end else begin
      in_service <= (state_next != IVP_IDLE);
    end
  end

endmodule : ivp_ctrl

// File: test/ivp_ctrl_asserts.sv
// concurrent checks on the controller ports
`timescale 1ns/100ps

module ivp_ctrl_asserts (
  input wire logic clk,
  input wire logic rst,
  input wire logic [ivp_pkg::IVP_NUM_IRQ-1:0] irq_flag_clear,
  input wire logic [3:0] cpu_priority_level,
  input wire logic entry_ack,
  input wire logic return_req,
  input wire logic cpu_irq_req,
  input wire ivp_pkg::ivp_pend_s pending_vector_status,
  input wire logic [ivp_pkg::IVP_NUM_IRQ-1:0] request_flag_bank,
  input wire logic [ivp_pkg::IVP_NUM_TRAP-1:0] trap_flag_bank,
  input wire logic [23:0] isr_address,
  input wire logic entry_done,
  input wire logic return_done,
  input wire logic in_service
);
  import ivp_pkg::*;

  // one clock domain, so one default clocking and reset
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////
  entry_latency_a: assert property (
    entry_ack && cpu_irq_req |-> ##1 !entry_done [*4] ##1 entry_done)
    else $error("entry done not four cycles after ack");
  return_latency_a: assert property (
    return_done |-> $past(return_req, 4) && !in_service)
    else $error("return done without return three cycles before");
  service_span_a: assert property (
    entry_done |-> in_service && $past(in_service, 3))
    else $error("service flag not standing through entry");
  flag_sticky_a: assert property (
    ($past(request_flag_bank) & ~request_flag_bank & ~$past(irq_flag_clear)) == '0)
    else $error("request flag dropped without clear");
  reserved_slots_a: assert property (
    (request_flag_bank & IVP_IRQ_RSVD) == '0 && (trap_flag_bank & ~IVP_TRAP_IMPL) == '0)
    else $error("reserved slot raised a flag");
  merge_request_a: assert property (
    cpu_irq_req |-> $past(|{request_flag_bank, trap_flag_bank}))
    else $error("cpu request without any flag");
  level_above_a: assert property (
    cpu_irq_req && pending_vector_status.pending_vector_number >= 7'h08
    |-> pending_vector_status.pending_priority_level > $past(cpu_priority_level))
    else $error("user request not above cpu level");
  level_seven_a: assert property (
    cpu_irq_req && $past(cpu_priority_level) >= 4'h7
    |-> pending_vector_status.pending_vector_number < 7'h08)
    else $error("user request passed cpu level seven");
  isr_hold_a: assert property (
    !entry_done |-> $stable(isr_address))
    else $error("service address moved outside entry");
endmodule : ivp_ctrl_asserts

// File: test/ivp_cpu_model.sv
// cpu entry side: takes a request, runs a service, returns
`timescale 1ns/100ps

module ivp_cpu_model (
  input wire logic clk,
  input wire logic slow,
  input wire logic cpu_irq_req,
  input wire logic entry_done,
  input wire logic return_done,
  output logic entry_ack,
  output logic return_req
);
  // slow mode lets several requests pile up before the ack
  // one process owns both outputs, idle values first
  initial begin
    entry_ack = 1'b0;
    return_req = 1'b0;
    forever begin
      @(posedge clk);
      if (cpu_irq_req === 1'b1) begin
        repeat (slow ? 6 : 0) @(posedge clk);
        entry_ack <= 1'b1;
        // held until an edge sees it with the request
        do @(posedge clk); while (cpu_irq_req !== 1'b1);
        entry_ack <= 1'b0;
        do @(posedge clk); while (entry_done !== 1'b1);
        // at least one spare cycle, service is entered by then
        repeat (slow ? 4 : 1) @(posedge clk);
        return_req <= 1'b1;
        @(posedge clk);
        return_req <= 1'b0;
        do @(posedge clk); while (return_done !== 1'b1);
      end
    end
  end
endmodule : ivp_cpu_model

// File: test/ivp_ctrl_tb_top.sv
// self-checking bench for the vector and priority controller
`timescale 1ns/100ps

module ivp_ctrl_tb_top;
  import ivp_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [IVP_NUM_IRQ-1:0] raw = '0, fclr = '0, en = '0, flags;
  logic [IVP_NUM_TRAP-1:0] trap = '0, tclr = '0, tflags;
  ivp_prio_t [IVP_NUM_IRQ-1:0] prio = '0;
  logic [15:0] ctl2 = 16'h0000;
  logic [3:0] cpu_lvl = 4'h0;
  logic slow = 1'b0, ack, ret, irq, edone, rdone, insvc, wen = 1'b0;
  logic [7:0] widx = 8'h00;
  logic [23:0] wdat = 24'h00_0000, isr;
  ivp_pend_s pend;
  logic [23:0] tbl [256];
  logic [34:0] expq [$];
  logic [15:0] seed = 16'h03ce;
  int err_total = 0, check_count = 0;

  always #50 clk = ~clk;

  ivp_ctrl dut (.clk(clk), .rst(rst), .irq_req_raw(raw), .trap_req(trap),
    .irq_flag_clear(fclr), .trap_flag_clear(tclr), .irq_enable(en),
    .source_priority_bank(prio), .second_interrupt_control(ctl2),
    .cpu_priority_level(cpu_lvl), .entry_ack(ack), .return_req(ret), .vt_wr_en(wen),
    .vt_wr_index(widx), .vt_wr_data(wdat), .cpu_irq_req(irq),
    .pending_vector_status(pend), .request_flag_bank(flags), .trap_flag_bank(tflags),
    .isr_address(isr), .entry_done(edone), .return_done(rdone), .in_service(insvc));

  ivp_cpu_model u_cpu (.clk(clk), .slow(slow), .cpu_irq_req(irq), .entry_done(edone),
    .return_done(rdone), .entry_ack(ack), .return_req(ret));

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    lfsr_next = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next

  task automatic check_eq(input logic [34:0] exp, input logic [34:0] act);
    check_count++;
    if (act !== exp) begin
      err_total++;
      $display("wrong value at %0t: expected %h got %h", $time, exp, act);
    end
  endtask : check_eq

  // note vector, level and table word that the next entry must show
  task automatic expect_entry(input logic [6:0] vec, input logic [3:0] lvl);
    logic [7:0] idx;
    idx = (ctl2[IVP_ALT_SEL_BIT] ? IVP_ALT_BASE_WORD : IVP_PRI_BASE_WORD) + {1'b0, vec};
    expq.push_back({vec, lvl, tbl[idx]});
  endtask : expect_entry

  // one-cycle pulse on a request line, called at a falling edge
  task automatic fire(input int n, input logic [2:0] lv);
    prio[n] = lv;
    en[n] = 1'b1;
    raw[n] = 1'b1;
    @(negedge clk);
    raw[n] = 1'b0;
  endtask : fire

  // bounded wait until every noted entry has come and gone
  task automatic settle();
    int k;
    for (k = 0; k < 400 && (expq.size() != 0 || insvc !== 1'b0); k++) @(negedge clk);
    check_eq({34'(expq.size()), insvc}, '0);
  endtask : settle

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish

  ////////////////////////////////////////////////////////////////////////////
  // service software: compare each entry, then clear its flag once
  always @(negedge clk) begin
    if (edone === 1'b1) begin
      check_eq(expq.size() ? expq.pop_front() : '0, {pend, isr});
    end
    fclr = (edone === 1'b1 && pend.pending_vector_number >= IVP_VEC_OFFSET) ?
      72'h1 << (pend.pending_vector_number - IVP_VEC_OFFSET) : '0;
    tclr = (edone === 1'b1 && pend.pending_vector_number < IVP_VEC_OFFSET) ?
      8'h1 << pend.pending_vector_number[2:0] : '0;
  end

  // cut a hang short
  initial begin
    repeat (8000) @(posedge clk);
    err_total++;
    tally_and_finish();
  end

  initial begin
    repeat (20) @(negedge clk);
    rst = 1'b0;
    check_eq({irq, insvc, edone, isr}, '0);
    check_eq({|flags, |tflags, rdone, pend}, '0);
    // table words from the shift register
    for (int i = 0; i < 256; i++) begin
      seed = lfsr_next(seed);
      tbl[i] = {seed[7:0], seed};
      wen = 1'b1;
      widx = i[7:0];
      wdat = tbl[i];
      @(negedge clk);
    end
    wen = 1'b0;
    // plain entry, reserved line pulsed first
    cpu_lvl = 4'h3;
    fire(15, 3'h7);
    expect_entry(7'(IVP_UART1_RX_IRQ + 8), 4'h5);
    fire(IVP_UART1_RX_IRQ, 3'h5);
    settle();
    // alternate table, other control bits random
    ctl2 = {1'b1, seed[14:0]};
    expect_entry(7'd19, 4'h5);
    fire(IVP_UART1_RX_IRQ, 3'h5);
    settle();
    ctl2 = 16'h0000;
    // level zero and disabled sources never request
    cpu_lvl = 4'h1;
    slow = 1'b1;
    prio[9] = 3'h6;
    en[7] = 1'b1;
    raw[7] = 1'b1;
    raw[9] = 1'b1;
    @(negedge clk);
    raw[7] = 1'b0;
    raw[9] = 1'b0;
    expect_entry(7'd58, 4'h6);
    expect_entry(7'd11, 4'h4);
    expect_entry(7'd48, 4'h4);
    fire(40, 3'h4);
    fire(3, 3'h4);
    fire(50, 3'h6);
    settle();
    slow = 1'b0;
    check_eq(35'(flags[9:7]), 35'h5);
    // cpu level seven blocks users, a trap still enters
    cpu_lvl = 4'h7;
    fire(3, 3'h7);
    repeat (12) @(negedge clk);
    check_eq({irq, flags[3]}, 35'h1);
    expect_entry(7'd2, 4'hd);
    trap[2] = 1'b1;
    @(negedge clk);
    trap[2] = 1'b0;
    settle();
    check_eq(35'(tflags), '0);
    expect_entry(7'd11, 4'h7);
    cpu_lvl = 4'h6;
    settle();
    tally_and_finish();
  end
endmodule : ivp_ctrl_tb_top

bind ivp_ctrl ivp_ctrl_asserts u_chk (.clk, .rst, .irq_flag_clear, .cpu_priority_level,
  .entry_ack, .return_req, .cpu_irq_req, .pending_vector_status, .request_flag_bank,
  .trap_flag_bank, .isr_address, .entry_done, .return_done, .in_service);
